/* File: include/adf_map.vh */
// Register map, field positions, reset values and timing for the converter
`ifndef ADF_MAP_VH
`define ADF_MAP_VH

// Register byte offsets on the register bus
`define ADF_OFF_CTRL0 8'h00
`define ADF_OFF_CTRL1 8'h04
`define ADF_OFF_APSEL 8'h08
`define ADF_OFF_RESH 8'h0c
`define ADF_OFF_RESL 8'h10
`define ADF_OFF_IRQEN 8'h14
`define ADF_OFF_IRQFL 8'h18

// Control register zero fields
`define ADF_C0_RJ 7
`define ADF_C0_REF_HI 6
`define ADF_C0_REF_LO 5
`define ADF_C0_CHS_HI 4
`define ADF_C0_CHS_LO 2
`define ADF_C0_GO 1
`define ADF_C0_EN 0

// Control register one field
`define ADF_C1_CS_HI 6
`define ADF_C1_CS_LO 4

// Conversion-done bit in the interrupt flag and enable registers
`define ADF_IRQ_DONE 6

// Reset values
`define ADF_RST_CTRL0 8'h00
`define ADF_RST_CS 3'h0
`define ADF_RST_APSEL 8'hff
`define ADF_RST_IRQEN 8'h00

// Result width and first trial bit
`define ADF_RES_BITS 10
`define ADF_TRIAL_MSB 10'h200
`define ADF_MSB_IDX 4'h9

// Timing: system clock period, slowest internal oscillator period
`define ADF_CLK_NS 40
`define ADF_FRC_NS 2000
`define ADF_FRC_CYC ((`ADF_FRC_NS + `ADF_CLK_NS - 1) / `ADF_CLK_NS)
`define ADF_ABORT_TADS 2'h2

// Bus responses
`define ADF_RESP_OK 2'b00
`define ADF_RESP_ERR 2'b10

`endif

/* File: rtl/adf_sync3.v */
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/10ps
`default_nettype none

module adf_sync3 (
  input wire mclk,
  input wire rst,
  input wire din,
  output reg dout
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // Stage one feeds only stage two; change counts once two and three agree
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end

endmodule // adf_sync3

`default_nettype wire

/* File: rtl/adf_tad_div.v */
// Conversion clock divider: one-cycle tick per conversion clock period
`timescale 1ns/10ps
`default_nettype none
`include "adf_map.vh"

module adf_tad_div (
  input wire mclk,
  input wire rst,
  input wire run,
  input wire [2:0] sel,
  output reg tick
);

  // Whole-number count first, then cut to the counter width on purpose
  localparam integer FRC_FULL = `ADF_FRC_CYC;
  localparam [6:0] FRC_DIV = FRC_FULL[6:0];

  reg [6:0] cnt_q;

  // Divide ratio for each clock select code
  function [6:0] divOf;
    input [2:0] s;
    begin
      case (s)
        3'h0: divOf = 7'h02;
        3'h1: divOf = 7'h08;
        3'h2: divOf = 7'h20;
        3'h4: divOf = 7'h04;
        3'h5: divOf = 7'h10;
        3'h6: divOf = 7'h40;
        default: divOf = FRC_DIV;
      endcase
    end
  endfunction

  // Counter held at zero while idle so each run starts a whole period
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 7'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_q <= 7'h00;
      tick <= 1'b0;
    end else if (cnt_q == divOf(sel) - 7'h01) begin
      cnt_q <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 7'h01;
      tick <= 1'b0;
    end
  end

endmodule // adf_tad_div

`default_nettype wire

/* File: rtl/adf_result_ctrl.v */
// Converter control, result formatting and register slave on AXI4-Lite
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "adf_map.vh"

// How it works
// R01: Left format puts result bits 1-0 in low byte bits 7-6.
// R02: Software ignores low byte bits 5-0 in left format.
// R03: Right format puts result bits 9-8 in high byte bits 1-0.
// R04: Right format puts result bits 7-0 in low byte bits 7-0.
// R05: Software waits an acquisition period before starting a conversion.
// R06: Each conversion resolves one of 1024 codes, ten bits.
// R07: Result bytes have no reset; any reset leaves them unchanged.
// R08: Control zero bit 7 set selects right format, clear selects left.
// R09: Left format puts result bits 9-2 across the high byte.
// R10: On completion clear go, set done flag, load both bytes.
// R11: Early go clear keeps result, waits two periods, then acquires.
// R12: Both result bytes load in the same clock cycle.
module adf_result_ctrl (
  input wire mclk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cmpAbove,
  output reg sampleEn,
  output reg [9:0] trialCode,
  output reg [2:0] chanSel,
  output reg [1:0] refSel,
  output reg [7:0] analogPinSel,
  output reg irq
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ACQ = 4'b0010;
  localparam [3:0] ST_CONV = 4'b0100;
  localparam [3:0] ST_ABORT = 4'b1000;
  localparam [7:0] RST_C0 = `ADF_RST_CTRL0;

  // Register state
  reg rightJust_q;
  reg enable_q;
  reg go_q;
  reg [2:0] clkSel_q;
  reg [7:0] irqEn_q;
  reg doneFlag_q;
  reg [7:0] resHigh_q;
  reg [7:0] resLow_q;

  // Converter state
  reg [3:0] state_q;
  reg [3:0] bitIdx_q;
  reg phase_q;
  reg [1:0] abortCnt_q;

  // Bus state
  reg [7:0] awAddr_q;
  reg awHeld_q;
  reg [7:0] wByte_q;
  reg wStrb0_q;
  reg wHeld_q;

  wire tadTick;
  wire cmpSync;

  // Write strobes from the decoded held address
  reg wrCtrl0;
  reg wrCtrl1;
  reg wrApsel;
  reg wrResH;
  reg wrResL;
  reg wrIrqEn;
  reg wrIrqFl;
  reg wrHit;
  reg [7:0] rdByte;
  reg rdHit;

  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
  wire wrOk = doWrite & wStrb0_q;
  wire arTake = s_axi_arvalid & s_axi_arready;

  wire stIdle = state_q[0];
  wire stAcq = state_q[1];
  wire stConv = state_q[2];
  wire stAbort = state_q[3];

  // Software go edges seen through a control zero write
  wire swGoSet = wrCtrl0 & wByte_q[`ADF_C0_GO];
  wire swGoClr = wrCtrl0 & ~wByte_q[`ADF_C0_GO];
  wire swEnNew = wrCtrl0 ? wByte_q[`ADF_C0_EN] : enable_q;

  // One bit of the successive approximation, lsb index 0
  function [9:0] bitMask;
    input [3:0] idx;
    begin
      bitMask = 10'h001 << idx;
    end
  endfunction

  // Place a ten-bit result into high and low bytes per format
  function [15:0] fmtResult;
    input rj;
    input [9:0] r;
    begin
      if (rj) begin
        fmtResult = {6'h00, r[9:8], r[7:0]}; // R03 R04 R08
      end else begin
        fmtResult = {r[9:2], r[1:0], 6'h00}; // R09 R01 R08
      end
    end
  endfunction

  // Comparator decision on the settled trial bit
  wire sampleStep = stConv & tadTick & phase_q;
  wire [9:0] keepCode = cmpSync ? trialCode
                                : (trialCode & ~bitMask(bitIdx_q));
  wire convAbort = stConv & (swGoClr | ~swEnNew);
  wire doneNow = sampleStep & (bitIdx_q == 4'h0) & ~convAbort;
  wire [15:0] fmtNew = fmtResult(rightJust_q, keepCode);

  // Comparator is an analog pin, so it is synchronised first
  adf_sync3 u_cmpSync (
    .mclk(mclk),
    .rst(rst),
    .din(cmpAbove),
    .dout(cmpSync)
  );

  // Conversion clock runs only while converting or settling an abort;
  // it restarts at the abort so the settling wait is two whole periods
  adf_tad_div u_tadDiv (
    .mclk(mclk),
    .rst(rst),
    .run((stConv & ~convAbort) | stAbort), // R11
    .sel(clkSel_q),
    .tick(tadTick)
  );

  // Address decode for writes
  always @* begin
    wrCtrl0 = 1'b0;
    wrCtrl1 = 1'b0;
    wrApsel = 1'b0;
    wrResH = 1'b0;
    wrResL = 1'b0;
    wrIrqEn = 1'b0;
    wrIrqFl = 1'b0;
    wrHit = 1'b1;
    if (awAddr_q == `ADF_OFF_CTRL0) begin
      wrCtrl0 = wrOk;
    end else if (awAddr_q == `ADF_OFF_CTRL1) begin
      wrCtrl1 = wrOk;
    end else if (awAddr_q == `ADF_OFF_APSEL) begin
      wrApsel = wrOk;
    end else if (awAddr_q == `ADF_OFF_RESH) begin
      wrResH = wrOk;
    end else if (awAddr_q == `ADF_OFF_RESL) begin
      wrResL = wrOk;
    end else if (awAddr_q == `ADF_OFF_IRQEN) begin
      wrIrqEn = wrOk;
    end else if (awAddr_q == `ADF_OFF_IRQFL) begin
      wrIrqFl = wrOk;
    end else begin
      wrHit = 1'b0;
    end
  end

  // Address decode for reads; unimplemented bits read zero
  always @* begin
    rdByte = 8'h00;
    rdHit = 1'b1;
    if (s_axi_araddr == `ADF_OFF_CTRL0) begin
      rdByte = {rightJust_q, refSel, chanSel, go_q, enable_q};
    end else if (s_axi_araddr == `ADF_OFF_CTRL1) begin
      rdByte = {1'b0, clkSel_q, 4'h0};
    end else if (s_axi_araddr == `ADF_OFF_APSEL) begin
      rdByte = analogPinSel;
    end else if (s_axi_araddr == `ADF_OFF_RESH) begin
      rdByte = resHigh_q;
    end else if (s_axi_araddr == `ADF_OFF_RESL) begin
      rdByte = resLow_q;
    end else if (s_axi_araddr == `ADF_OFF_IRQEN) begin
      rdByte = irqEn_q;
    end else if (s_axi_araddr == `ADF_OFF_IRQFL) begin
      rdByte = {1'b0, doneFlag_q, 6'h00};
    end else begin
      rdHit = 1'b0;
    end
  end

  // Write channel: address and data taken in either order
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      awAddr_q <= 8'h00;
      awHeld_q <= 1'b0;
      wByte_q <= 8'h00;
      wStrb0_q <= 1'b0;
      wHeld_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADF_RESP_OK;
    end else begin
      if (awTake) begin
        awAddr_q <= s_axi_awaddr;
        awHeld_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (wTake) begin
        wByte_q <= s_axi_wdata[7:0];
        wStrb0_q <= s_axi_wstrb[0];
        wHeld_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // Both halves in hand: apply and answer next edge
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `ADF_RESP_OK : `ADF_RESP_ERR;
      end
      // Readies return only once the response is accepted
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: one read at a time, data one edge after address
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ADF_RESP_OK;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rdByte};
      s_axi_rresp <= rdHit ? `ADF_RESP_OK : `ADF_RESP_ERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Software configuration registers
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rightJust_q <= RST_C0[`ADF_C0_RJ];
      refSel <= 2'h0;
      chanSel <= 3'h0;
      enable_q <= 1'b0;
      clkSel_q <= `ADF_RST_CS;
      analogPinSel <= `ADF_RST_APSEL;
      irqEn_q <= `ADF_RST_IRQEN;
    end else begin
      if (wrCtrl0) begin
        rightJust_q <= wByte_q[`ADF_C0_RJ]; // R08
        refSel <= wByte_q[`ADF_C0_REF_HI:`ADF_C0_REF_LO];
        chanSel <= wByte_q[`ADF_C0_CHS_HI:`ADF_C0_CHS_LO];
        enable_q <= wByte_q[`ADF_C0_EN];
      end
      if (wrCtrl1) begin
        clkSel_q <= wByte_q[`ADF_C1_CS_HI:`ADF_C1_CS_LO];
      end
      if (wrApsel) begin
        analogPinSel <= wByte_q;
      end
      if (wrIrqEn) begin
        irqEn_q <= wByte_q;
      end
    end
  end

  // Done flag is sticky; a completion in the clearing cycle wins
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      doneFlag_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      doneFlag_q <= (doneFlag_q
                     & ~(wrIrqFl & wByte_q[`ADF_IRQ_DONE]))
                    | doneNow; // R10
      irq <= doneFlag_q & irqEn_q[`ADF_IRQ_DONE];
    end
  end

  // Result bytes deliberately have no reset so any reset preserves them
  always @(posedge mclk) begin
    if (doneNow) begin
      resHigh_q <= fmtNew[15:8]; // R10 R12
      resLow_q <= fmtNew[7:0]; // R12 R07
    end else begin
      if (wrResH) begin
        resHigh_q <= wByte_q;
      end
      if (wrResL) begin
        resLow_q <= wByte_q;
      end
    end
  end

  // Converter sequence: acquire, approximate ten bits, or settle abort
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      go_q <= 1'b0;
      sampleEn <= 1'b0;
      trialCode <= 10'h000;
      bitIdx_q <= 4'h0;
      phase_q <= 1'b0;
      abortCnt_q <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          go_q <= 1'b0;
          // Go written with the enable itself is ignored
          if (enable_q) begin
            state_q <= ST_ACQ;
            sampleEn <= 1'b1; // R05
          end
        end
        ST_ACQ: begin
          if (!swEnNew) begin
            state_q <= ST_IDLE;
            sampleEn <= 1'b0;
          end else if (swGoSet) begin
            // Acquisition time is the software's to honour
            state_q <= ST_CONV; // R05
            go_q <= 1'b1;
            sampleEn <= 1'b0;
            trialCode <= `ADF_TRIAL_MSB; // R06
            bitIdx_q <= `ADF_MSB_IDX; // R06
            phase_q <= 1'b0;
          end
        end
        ST_CONV: begin
          if (!swEnNew) begin
            state_q <= ST_IDLE;
            go_q <= 1'b0;
          end else if (swGoClr) begin
            // Partial code is dropped; old result stays
            state_q <= ST_ABORT; // R11
            go_q <= 1'b0;
            abortCnt_q <= 2'h0;
          end else if (tadTick & !phase_q) begin
            // First period lets the trial settle at the comparator
            phase_q <= 1'b1;
          end else if (sampleStep) begin
            phase_q <= 1'b0;
            if (bitIdx_q == 4'h0) begin
              state_q <= ST_ACQ; // R10
              go_q <= 1'b0; // R10
              sampleEn <= 1'b1;
              trialCode <= keepCode;
            end else begin
              trialCode <= keepCode | bitMask(bitIdx_q - 4'h1);
              bitIdx_q <= bitIdx_q - 4'h1;
            end
          end
        end
        ST_ABORT: begin
          if (!swEnNew) begin
            state_q <= ST_IDLE;
          end else if (tadTick) begin
            if (abortCnt_q == `ADF_ABORT_TADS - 2'h1) begin
              state_q <= ST_ACQ; // R11
              sampleEn <= 1'b1; // R11
            end else begin
              abortCnt_q <= abortCnt_q + 2'h1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          go_q <= 1'b0;
          sampleEn <= 1'b0;
        end
      endcase
    end
  end

endmodule // adf_result_ctrl

`default_nettype wire

/* File: dv/adf_result_ctrl_properties.sv */
// Port-level checks of the converter register block
`timescale 1ns/10ps
`default_nettype none
`include "adf_map.vh"

module adf_result_ctrl_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sampleEn,
  input wire logic [2:0] chanSel,
  input wire logic [7:0] analogPinSel,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Both write halves taken at one edge, as the bench offers them
  logic wrTake;
  logic arTake;
  logic wrOn;
  assign wrTake = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  assign arTake = s_axi_arvalid & s_axi_arready;
  assign wrOn = wrTake & s_axi_wstrb[0];

  write_answer_a: assert property (wrTake |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  bad_wr_resp_a: assert property (wrTake && s_axi_awaddr > `ADF_OFF_IRQFL
    |-> ##2 s_axi_bresp == `ADF_RESP_ERR) else $error("unmapped write okay");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("second address taken");
  read_answer_a: assert property (arTake |=> s_axi_rvalid && !s_axi_arready
    && s_axi_rdata[31:8] == 24'h0) else $error("read answer wrong");
  bad_rd_resp_a: assert property (arTake && s_axi_araddr > `ADF_OFF_IRQFL
    |=> s_axi_rresp == `ADF_RESP_ERR) else $error("unmapped read okay");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  pin_sel_a: assert property (wrOn && s_axi_awaddr == `ADF_OFF_APSEL
    |-> ##3 analogPinSel == $past(s_axi_wdata[7:0], 3))
    else $error("pin select not written");
  chan_sel_a: assert property (wrOn && s_axi_awaddr == `ADF_OFF_CTRL0
    |-> ##3 chanSel == $past(s_axi_wdata[4:2], 3))
    else $error("channel select not written");
  irq_mask_a: assert property (wrOn && s_axi_awaddr == `ADF_OFF_IRQEN
    && !s_axi_wdata[6] |-> ##3 !irq) else $error("masked interrupt high");
  acq_off_a: assert property (wrOn && s_axi_awaddr == `ADF_OFF_CTRL0
    && !s_axi_wdata[0] |-> ##3 !sampleEn) else $error("disabled yet sampling");

  cover property (s_axi_bvalid && s_axi_bresp == `ADF_RESP_ERR);
  cover property ($rose(irq));
  cover property ($fell(sampleEn));
  cover property ($rose(sampleEn));
endmodule // adf_result_ctrl_props

bind adf_result_ctrl adf_result_ctrl_props adf_result_ctrl_props_i (.mclk,
  .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sampleEn, .chanSel,
  .analogPinSel, .irq);
`default_nettype wire

/* File: dv/adf_result_ctrl_tb_top.sv */
// Self-checking regression of the converter register block
`timescale 1ns/10ps
`default_nettype none
`include "adf_map.vh"

module adf_result_ctrl_tb_top;
  logic mclk, rst, cmpAbove, sampleEn, irq;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, analogPinSel;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, refSel, rs;
  logic [9:0] trialCode, vin, v;
  logic [2:0] chanSel;
  int bad_count, checks_done, cyc, n;
  logic [2:0] csT [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};

  adf_result_ctrl adf_result_ctrl_i (.mclk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmpAbove, .sampleEn, .trialCode, .chanSel,
    .refSel, .analogPinSel, .irq);

  // Clock at 25 MHz
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Comparator seen as a pin; one flop of lag, so fastest clocks are skipped
  always @(posedge mclk) cmpAbove <= (vin >= trialCode);

  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      bad_count++;
    end
  endtask

  // Write: both halves offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic pa, pw, ha, hw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge mclk);
      ha = s_axi_awready;
      hw = s_axi_wready;
      @(posedge mclk);
      if (ha) begin pa = 1'b0; s_axi_awvalid <= 1'b0; end
      if (hw) begin pw = 1'b0; s_axi_wvalid <= 1'b0; end
    end
    // Response taken late at times, so the hold checks see a stall
    repeat ($urandom_range(2)) @(posedge mclk);
    s_axi_bready <= 1'b1;
    do begin
      @(negedge mclk);
      ha = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge mclk);
    end while (!ha);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic h;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin @(negedge mclk); h = s_axi_arready; @(posedge mclk); end
    while (!h);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge mclk);
    s_axi_rready <= 1'b1;
    do begin
      @(negedge mclk);
      h = s_axi_rvalid;
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge mclk);
    end while (!h);
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [31:0] hiExp(input logic rj, input logic [9:0] x);
    return rj ? {30'h0, x[9:8]} : {24'h0, x[9:2]};
  endfunction

  function automatic logic [31:0] loExp(input logic rj, input logic [9:0] x);
    return rj ? {24'h0, x[7:0]} : {24'h0, x[1:0], 6'h0};
  endfunction

  task automatic results(input logic rj, input logic [9:0] x);
    rd(`ADF_OFF_RESH);
    chk(rv, hiExp(rj, x));
    rd(`ADF_OFF_RESL);
    chk(rv, loExp(rj, x));
  endtask

  // One conversion: enable, acquire, go, poll, read, clear flag
  task automatic conv(input logic rj, input logic [2:0] cs, input logic ie);
    vin = v;
    wr(`ADF_OFF_CTRL1, {1'b0, cs, 4'h0});
    wr(`ADF_OFF_IRQEN, {1'b0, ie, 6'h0});
    wr(`ADF_OFF_CTRL0, {rj, 6'h0, 1'b1});
    repeat (20) @(posedge mclk);
    wr(`ADF_OFF_CTRL0, {rj, 5'h0, 2'h3});
    do rd(`ADF_OFF_CTRL0); while (rv[1] !== 1'b0);
    results(rj, v);
    rd(`ADF_OFF_IRQFL);
    chk(rv, 32'h40);
    @(negedge mclk);
    chk({31'h0, irq}, {31'h0, ie});
    chk({31'h0, sampleEn}, 32'h1);
    chk({22'h0, trialCode}, {22'h0, v});
    @(posedge mclk);
    wr(`ADF_OFF_IRQFL, 8'h40);
    rd(`ADF_OFF_IRQFL);
    chk(rv, 32'h0);
    @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    @(posedge mclk);
  endtask

  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_rready} = 17'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    {bad_count, checks_done, cyc, vin, v} = 0;
    rst = 1'b1;
    void'($urandom(81));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Result bytes power up undefined, so give them a value first
    wr(`ADF_OFF_RESH, 8'h00);
    wr(`ADF_OFF_RESL, 8'h00);
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4));
      chk(rv, (i == 2) ? 32'hff : 32'h0);
    end
    rd(8'h1c);
    chk({30'h0, rs}, {30'h0, `ADF_RESP_ERR});
    wr(8'h40, 8'h5a);
    chk({30'h0, rs}, {30'h0, `ADF_RESP_ERR});
    v = 10'($urandom);
    wr(`ADF_OFF_APSEL, v[7:0]);
    rd(`ADF_OFF_APSEL);
    chk(rv, {24'h0, v[7:0]});
    // Byte lane 0 off: answered, but the register stays
    s_axi_wstrb <= 4'h0;
    wr(`ADF_OFF_APSEL, ~v[7:0]);
    s_axi_wstrb <= 4'h1;
    chk({30'h0, rs}, {30'h0, `ADF_RESP_OK});
    rd(`ADF_OFF_APSEL);
    chk(rv, {24'h0, v[7:0]});
    for (int i = 0; i < 8; i++) begin
      wr(`ADF_OFF_CTRL1, {1'b0, 3'(i), 4'hf});
      rd(`ADF_OFF_CTRL1);
      chk(rv, {25'h0, 3'(i), 4'h0});
    end
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 10'h0 : (i == 1) ? 10'h3ff : 10'($urandom);
      conv(i[0], csT[i], i[1]);
    end
    // Early stop of a slow conversion keeps the old result
    vin = ~v;
    wr(`ADF_OFF_CTRL1, 8'h60);
    wr(`ADF_OFF_CTRL0, 8'h83);
    repeat (100) @(posedge mclk);
    wr(`ADF_OFF_CTRL0, 8'h81);
    n = 0;
    @(negedge mclk);
    chk({31'h0, sampleEn}, 32'h0);
    while (sampleEn !== 1'b1 && n < 300) begin @(negedge mclk); n++; end
    chk({31'h0, n >= 100 && n <= 140}, 32'h1);
    @(posedge mclk);
    results(1'b1, v);
    rd(`ADF_OFF_IRQFL);
    chk(rv, 32'h0);
    // Enable off with go clear: idle at once, other fields kept
    wr(`ADF_OFF_CTRL0, 8'hfc);
    @(negedge mclk);
    chk({31'h0, sampleEn}, 32'h0);
    chk({30'h0, refSel}, 32'h3);
    chk({29'h0, chanSel}, 32'h7);
    @(posedge mclk);
    rd(`ADF_OFF_CTRL0);
    chk(rv, 32'hfc);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    results(1'b1, v);
    rd(`ADF_OFF_CTRL0);
    chk(rv, 32'h0);
    report_and_stop();
  end
endmodule // adf_result_ctrl_tb_top
`default_nettype wire
